/* File: asq_pkg.sv */
// constants, state encoding and the channel search shared by the scan sequencer files
// assumes a 32-bit aligned register map reached over an AXI4-Lite slave port
package asq_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_SCAN_CONTROL   = 32'hFFFFE800;
	localparam logic [31:0] ADDR_CHANNEL_SELECT = 32'hFFFFE820;
	localparam logic [31:0] ADDR_CONV_STATUS    = 32'hFFFFE824;
	localparam logic [31:0] ADDR_IRQ_STATUS     = 32'hFFFFE828;
	localparam logic [31:0] ADDR_IRQ_MASK       = 32'hFFFFE82C;
	localparam logic [31:0] ADDR_RESULT_BASE    = 32'hFFFFE840;

	// sizes
	localparam int NUM_CH = 8;
	localparam int RES_W  = 12;
	localparam int REG_W  = 8;

	// scan_control field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_HWEN  = 1;
	localparam int CTRL_IE    = 4;
	localparam int CTRL_ACE   = 5;
	localparam int CTRL_MODE  = 6;

	// conv_status and irq status field positions
	localparam int STAT_FLAG      = 0;
	localparam int STAT_BUSY      = 1;
	localparam int IRQ_SCAN_END   = 0;
	localparam int IRQ_OVERRUN    = 1;

	// reset values
	localparam logic [7:0] SCAN_CONTROL_RST   = 8'h00;
	localparam logic [7:0] CHANNEL_SELECT_RST = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST       = 8'h00;

	// bus responses and channel search result meaning none left
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] CH_NONE     = 4'h8;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT  = 2'b10
	} asq_state_e;

	// lowest selected channel at or above from, CH_NONE when there is none
	function automatic logic [3:0] asq_next_ch(input logic [7:0] mask, input logic [3:0] from);
		logic [3:0] r;
		r = CH_NONE;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (i >= int'(from) && mask[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

endpackage

/* File: asq_result_mem.sv */
// per-channel result store: one write port for conversions, one clear port, registered read
// assumes a single clock; a conversion write beats a clear to the same entry
`timescale 1ns/1ps
module asq_result_mem
	import asq_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// conversion write
	input  wire logic             wr_en,
	input  wire logic [2:0]       wr_idx,
	input  wire logic [RES_W-1:0] wr_data,
	// clear after read
	input  wire logic             clr_en,
	input  wire logic [2:0]       clr_idx,
	// read
	input  wire logic             rd_en,
	input  wire logic [2:0]       rd_idx,
	output logic      [RES_W-1:0] rd_data
);

	logic [RES_W-1:0] mem_q [NUM_CH];
	logic [RES_W-1:0] rd_data_q;

	// storage; the newer result must survive a simultaneous clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			if (clr_en) begin
				mem_q[clr_idx] <= '0;
			end
			if (wr_en) begin
				mem_q[wr_idx] <= wr_data;
			end
		end
	end

	// read data register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= '0;
		end else if (rd_en) begin
			rd_data_q <= mem_q[rd_idx];
		end
	end

	assign rd_data = rd_data_q;

endmodule

/* File: asq_scan_sequencer.sv */
// scan sequencer for a 12-bit converter: registers, triggers, channel walk, results
// assumes an external converter core that answers each conv_start with one conv_done pulse
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module asq_scan_sequencer
	import asq_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// axi4-lite write
	input  wire logic [31:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	// axi4-lite read
	input  wire logic [31:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// hardware triggers, timer pulses active high
	input  wire logic             timer_trig_a,
	input  wire logic             timer_ch0_trig,
	input  wire logic             timer_ch4_trig_a,
	input  wire logic             timer_ch4_trig_b,
	input  wire logic             timer2_trig_a,
	input  wire logic             timer2_ch4_trig_a,
	input  wire logic             timer2_ch4_trig_b,
	input  wire logic             ext_trigger_in_n,
	// converter core
	output logic                  conv_start,
	output logic [2:0]            conv_channel,
	input  wire logic             conv_done,
	input  wire logic [RES_W-1:0] conv_result,
	// sample-and-hold control
	output logic [2:0]            sh_dedicated_hold,
	output logic                  sh_shared_sel,
	// interrupt
	output logic                  irq
);

	asq_state_e       state_q;
	logic [3:0]       cur_ch_q;
	logic [7:0]       scan_mask_q;
	logic             start_q, mode_q, ace_q, ie_q, hwen_q;
	logic [7:0]       chsel_q;
	logic             flag_q;
	logic [7:0]       irq_stat_q, irq_mask_q;
	logic             irq_q, ext_prev_q;
	logic             conv_start_q, sh_shared_q;
	logic [2:0]       conv_ch_q, sh_hold_q;
	logic             awready_q, wready_q, bvalid_q, aw_got_q, w_got_q;
	logic [1:0]       bresp_q, rresp_q;
	logic [31:0]      awaddr_q, wdata_q, araddr_q, rdata_q;
	logic [3:0]       wstrb_q;
	logic             arready_q, rd_pend_q, rvalid_q;
	logic [RES_W-1:0] mem_rd;

	// address decode of the result window, used for reads and writes
	function automatic logic is_result(input logic [31:0] a);
		return a[31:5] == ADDR_RESULT_BASE[31:5];
	endfunction

	// bus handshakes and register strobes
	logic aw_hs, w_hs, ar_hs, wr_commit, wr_lane, wr_hit, rd_done;
	logic wr_ctrl, wr_chsel, wr_stat, wr_istat, wr_imask;
	assign aw_hs     = s_axi_awvalid && awready_q;
	assign w_hs      = s_axi_wvalid && wready_q;
	assign ar_hs     = s_axi_arvalid && arready_q;
	assign wr_commit = aw_got_q && w_got_q && !bvalid_q;
	assign wr_lane   = wr_commit && wstrb_q[0];
	assign wr_ctrl   = wr_lane && awaddr_q == ADDR_SCAN_CONTROL;
	assign wr_chsel  = wr_lane && awaddr_q == ADDR_CHANNEL_SELECT;
	assign wr_stat   = wr_lane && awaddr_q == ADDR_CONV_STATUS;
	assign wr_istat  = wr_lane && awaddr_q == ADDR_IRQ_STATUS;
	assign wr_imask  = wr_lane && awaddr_q == ADDR_IRQ_MASK;
	assign wr_hit    = awaddr_q == ADDR_SCAN_CONTROL || awaddr_q == ADDR_CHANNEL_SELECT
		|| awaddr_q == ADDR_CONV_STATUS || awaddr_q == ADDR_IRQ_STATUS
		|| awaddr_q == ADDR_IRQ_MASK || is_result(awaddr_q);
	assign rd_done   = rvalid_q && s_axi_rready;

	// trigger detection; triggers are ignored entirely while the enable is low
	logic ext_fall, timer_any, hw_trig;
	assign ext_fall  = ext_prev_q && !ext_trigger_in_n;
	assign timer_any = timer_trig_a || timer_ch0_trig || timer_ch4_trig_a
		|| timer_ch4_trig_b || timer2_trig_a || timer2_ch4_trig_a
		|| timer2_ch4_trig_b;
	assign hw_trig   = hwen_q && (ext_fall || timer_any);

	// scan walk decisions
	logic       done_ev, scan_end, begin_scan, idle_empty;
	logic [3:0] nxt, first;
	assign first      = asq_next_ch(chsel_q, 4'h0);
	assign nxt        = asq_next_ch(scan_mask_q, 4'(cur_ch_q + 4'h1));
	assign done_ev    = state_q == ST_WAIT && conv_done;
	assign scan_end   = done_ev && start_q && nxt[3];
	assign begin_scan = (state_q == ST_IDLE && start_q && !first[3])
		|| (scan_end && mode_q && !first[3]);
	assign idle_empty = state_q == ST_IDLE && start_q && first[3] && !mode_q;

	// write channel: address and data taken in either order, response after both
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			awaddr_q  <= 32'h0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_got_q  <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
				awready_q <= 1'b0;
			end else if (!aw_got_q && !bvalid_q) begin
				awready_q <= 1'b1;
			end
			if (w_hs) begin
				w_got_q  <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
				wready_q <= 1'b0;
			end else if (!w_got_q && !bvalid_q) begin
				wready_q <= 1'b1;
			end
			if (wr_commit) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read data mux; result words sit in the low twelve bits
	logic [31:0] rd_word;
	logic        rd_hit;
	always_comb begin
		rd_word = 32'h0;
		rd_hit  = 1'b1;
		if (is_result(araddr_q)) begin
			rd_word = {20'h0, mem_rd};
		end else begin
			case (araddr_q)
				ADDR_SCAN_CONTROL:   rd_word = {24'h0, 1'b0, mode_q, ace_q, ie_q, 2'h0,
					hwen_q, start_q};
				ADDR_CHANNEL_SELECT: rd_word = {24'h0, chsel_q};
				ADDR_CONV_STATUS:    rd_word = {30'h0, state_q != ST_IDLE, flag_q};
				ADDR_IRQ_STATUS:     rd_word = {24'h0, irq_stat_q};
				ADDR_IRQ_MASK:       rd_word = {24'h0, irq_mask_q};
				default:             rd_hit  = 1'b0;
			endcase
		end
	end

	// read channel: answer one edge after the address is taken
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready_q <= 1'b0;
			araddr_q  <= 32'h0;
			rd_pend_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= RESP_OKAY;
		end else begin
			if (ar_hs) begin
				araddr_q  <= s_axi_araddr;
				arready_q <= 1'b0;
				rd_pend_q <= 1'b1;
			end else if (!rd_pend_q && !rvalid_q) begin
				arready_q <= 1'b1;
			end
			if (rd_pend_q) begin
				rd_pend_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= rd_word;
				rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rd_done) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// control register; a trigger in the same cycle as a stop write still starts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_q <= SCAN_CONTROL_RST[CTRL_START];
			hwen_q  <= SCAN_CONTROL_RST[CTRL_HWEN];
			ie_q    <= SCAN_CONTROL_RST[CTRL_IE];
			ace_q   <= SCAN_CONTROL_RST[CTRL_ACE];
			mode_q  <= SCAN_CONTROL_RST[CTRL_MODE];
			chsel_q <= CHANNEL_SELECT_RST;
		end else begin
			if ((scan_end && !mode_q) || idle_empty) begin
				start_q <= 1'b0;
			end
			if (wr_ctrl) begin
				start_q <= wdata_q[CTRL_START];
				hwen_q  <= wdata_q[CTRL_HWEN];
				ie_q    <= wdata_q[CTRL_IE];
				ace_q   <= wdata_q[CTRL_ACE];
				mode_q  <= wdata_q[CTRL_MODE];
			end
			if (hw_trig) begin
				start_q <= 1'b1;
			end
			if (wr_chsel) begin
				chsel_q <= wdata_q[REG_W-1:0];
			end
		end
	end

	// scan-end flag and sticky interrupt status; hardware set beats software clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q     <= 1'b0;
			irq_stat_q <= 8'h00;
			irq_mask_q <= IRQ_MASK_RST;
			irq_q      <= 1'b0;
			ext_prev_q <= 1'b1;
		end else begin
			ext_prev_q <= ext_trigger_in_n;
			if (wr_stat && !wdata_q[STAT_FLAG]) begin
				flag_q <= 1'b0;
			end
			if (scan_end) begin
				flag_q <= 1'b1;
			end
			if (wr_istat) begin
				irq_stat_q <= irq_stat_q & ~wdata_q[REG_W-1:0];
			end
			if (scan_end) begin
				irq_stat_q[IRQ_SCAN_END] <= 1'b1;
			end
			if (hw_trig && start_q) begin
				irq_stat_q[IRQ_OVERRUN] <= 1'b1;
			end
			if (wr_imask) begin
				irq_mask_q <= wdata_q[REG_W-1:0];
			end
			irq_q <= |(irq_stat_q & irq_mask_q & {7'h7F, ie_q});
		end
	end

	// channel walk; the channel set is snapshot at each scan start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q     <= ST_IDLE;
			cur_ch_q    <= 4'h0;
			scan_mask_q <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (begin_scan) begin
						cur_ch_q    <= first;
						scan_mask_q <= chsel_q;
						state_q     <= ST_ISSUE;
					end
				end
				ST_ISSUE: state_q <= ST_WAIT;
				ST_WAIT: begin
					if (done_ev) begin
						if (!start_q) begin
							state_q <= ST_IDLE;
						end else if (!nxt[3]) begin
							cur_ch_q <= nxt;
							state_q  <= ST_ISSUE;
						end else if (begin_scan) begin
							cur_ch_q    <= first;
							scan_mask_q <= chsel_q;
							state_q     <= ST_ISSUE;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// converter request and sample-and-hold steering
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_start_q <= 1'b0;
			conv_ch_q    <= 3'h0;
			sh_hold_q    <= 3'h0;
			sh_shared_q  <= 1'b0;
		end else begin
			conv_start_q <= state_q == ST_ISSUE;
			if (state_q == ST_ISSUE) begin
				conv_ch_q   <= cur_ch_q[2:0];
				sh_shared_q <= cur_ch_q < 4'h3;
			end else if (done_ev) begin
				sh_shared_q <= 1'b0;
			end
			if (begin_scan) begin
				sh_hold_q <= chsel_q[2:0];
			end else if (done_ev && cur_ch_q < 4'h3) begin
				sh_hold_q[cur_ch_q[1:0]] <= 1'b0;
			end
		end
	end

	// result store; a read with auto clear empties the word it returned
	asq_result_mem u_mem (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (done_ev),
		.wr_idx  (cur_ch_q[2:0]),
		.wr_data (conv_result),
		.clr_en  (rd_done && ace_q && is_result(araddr_q)),
		.clr_idx (araddr_q[4:2]),
		.rd_en   (ar_hs),
		.rd_idx  (s_axi_araddr[4:2]),
		.rd_data (mem_rd)
	);

	assign s_axi_awready     = awready_q;
	assign s_axi_wready      = wready_q;
	assign s_axi_bvalid      = bvalid_q;
	assign s_axi_bresp       = bresp_q;
	assign s_axi_arready     = arready_q;
	assign s_axi_rvalid      = rvalid_q;
	assign s_axi_rdata       = rdata_q;
	assign s_axi_rresp       = rresp_q;
	assign conv_start        = conv_start_q;
	assign conv_channel      = conv_ch_q;
	assign sh_dedicated_hold = sh_hold_q;
	assign sh_shared_sel     = sh_shared_q;
	assign irq               = irq_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence seq_end_single;
		scan_end && !mode_q;
	endsequence
	sequence seq_end_cont;
		scan_end && mode_q && !first[3] && !wr_ctrl;
	endsequence

	AST_SINGLE_STOPS: assert property (seq_end_single and (!hw_trig && !wr_ctrl) |=>
		!start_q && state_q == ST_IDLE) else $error("single scan did not stop");
	AST_CONT_REPEATS: assert property (seq_end_cont |=> state_q == ST_ISSUE ##1
		conv_start_q) else $error("continuous scan did not restart");
	AST_TIMER_START: assert property (hwen_q && timer_any |=> start_q)
		else $error("timer trigger lost");
	AST_EXT_START: assert property (hwen_q && $fell(ext_trigger_in_n) |=> start_q)
		else $error("external falling edge lost");
	AST_HW_OFF: assert property (!hwen_q && !start_q && !wr_ctrl |=> !start_q)
		else $error("start without enabled source");
	AST_DED_HOLD: assert property (begin_scan |=> sh_hold_q == $past(chsel_q[2:0]))
		else $error("dedicated holds not loaded");
	AST_IRQ_GATE: assert property (scan_end && ie_q && irq_mask_q[0] && !wr_ctrl
		&& !wr_istat |-> ##[1:2] irq_q) else $error("scan end interrupt missing");
	AST_NO_IRQ: assert property (irq_stat_q[1:0] == 2'h1 && !ie_q && !$past(ie_q)
		|=> !irq_q) else $error("interrupt while disabled");
	AST_FLAG_SET: assert property (scan_end |=> flag_q)
		else $error("scan end flag not set");
	AST_ASCEND: assert property (done_ev && start_q && !nxt[3] |=> ##1
		conv_ch_q > $past(conv_ch_q, 2)) else $error("channel order not ascending");

endmodule

/* File: asq_core_model.sv */
// converter core stand-in: answers each conv_start with one conv_done pulse
// assumes conv_channel is valid in the cycle that conv_start is high
`timescale 1ns/1ps
module asq_core_model
	import asq_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// request from the sequencer
	input  wire logic             conv_start,
	input  wire logic [2:0]       conv_channel,
	// bench controls: long answer time, low bits of every result
	input  wire logic             slow,
	input  wire logic [8:0]       base,
	// answer
	output logic                  conv_done,
	output logic      [RES_W-1:0] conv_result
);
	logic       busy_q;
	logic [3:0] cnt_q;
	logic [2:0] ch_q;

	// result holds its channel so a misfiled write shows; bus toggles when not valid
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q      <= 1'b0;
			cnt_q       <= 4'h0;
			ch_q        <= 3'h0;
			conv_done   <= 1'b0;
			conv_result <= 12'h000;
		end else begin
			conv_done   <= 1'b0;
			conv_result <= ~conv_result;
			if (conv_start) begin
				busy_q <= 1'b1;
				ch_q   <= conv_channel;
				cnt_q  <= slow ? 4'h6 : 4'h1;
			end else if (busy_q && cnt_q == 4'h0) begin
				busy_q      <= 1'b0;
				conv_done   <= 1'b1;
				conv_result <= {ch_q, base};
			end else if (busy_q) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule

/* File: asq_scan_sequencer_bench.sv */
// self-checking bench for the scan sequencer: register bus, triggers, scans, interrupt
// assumes asq_pkg and the core stand-in asq_core_model are compiled first
`timescale 1ns/1ps
module asq_scan_sequencer_bench
	import asq_pkg::*;
;
	logic             clk, rst, slow, ext_n, irq;
	logic [31:0]      awaddr, wdata, araddr, rdata;
	logic             awvalid, awready, wvalid, wready, bvalid, bready;
	logic             arvalid, arready, rvalid, rready;
	logic [3:0]       wstrb;
	logic [1:0]       bresp, rresp, last_resp;
	logic [6:0]       trg;
	logic             conv_start, conv_done, sh_shared;
	logic [2:0]       conv_channel, sh_hold;
	logic [RES_W-1:0] conv_result;
	logic [8:0]       base;
	int               err_count, checks_done, cycles;
	logic [2:0]       ch_q[$], hold_q[$];
	logic             sh_q[$];

	asq_scan_sequencer asq_scan_sequencer_i (.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.timer_trig_a(trg[0]), .timer_ch0_trig(trg[1]), .timer_ch4_trig_a(trg[2]),
		.timer_ch4_trig_b(trg[3]), .timer2_trig_a(trg[4]), .timer2_ch4_trig_a(trg[5]),
		.timer2_ch4_trig_b(trg[6]), .ext_trigger_in_n(ext_n),
		.conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
		.conv_result(conv_result), .sh_dedicated_hold(sh_hold), .sh_shared_sel(sh_shared),
		.irq(irq));

	asq_core_model asq_core_model_i (.clk(clk), .rst(rst), .conv_start(conv_start),
		.conv_channel(conv_channel), .slow(slow), .base(base), .conv_done(conv_done),
		.conv_result(conv_result));

	// free-running clock, 100 ns period
	always #50 clk = ~clk;

	// record every conversion request with the hold state seen alongside it
	always @(posedge clk) begin
		if (conv_start === 1'b1) begin
			ch_q.push_back(conv_channel);
			hold_q.push_back(sh_hold);
			sh_q.push_back(sh_shared);
		end
	end

	// hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		if (err_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		last_resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		last_resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	task automatic wait_flag;
		logic [31:0] d;
		do rd(ADDR_CONV_STATUS, d); while (d[STAT_FLAG] !== 1'b1);
	endtask

	task automatic clear_flags;
		wr(ADDR_CONV_STATUS, 32'h00000000);
		wr(ADDR_IRQ_STATUS, 32'h00000003);
		ch_q.delete();
		hold_q.delete();
		sh_q.delete();
	endtask

	function automatic logic [31:0] res(input int ch);
		return {20'h00000, 3'(ch), base};
	endfunction

	task automatic t_regs;
		logic [31:0] d;
		rdchk(ADDR_SCAN_CONTROL, {24'h000000, SCAN_CONTROL_RST});
		rdchk(ADDR_CHANNEL_SELECT, {24'h000000, CHANNEL_SELECT_RST});
		rdchk(ADDR_IRQ_MASK, {24'h000000, IRQ_MASK_RST});
		wr(ADDR_CHANNEL_SELECT, 32'h000000A5);
		chk(last_resp, RESP_OKAY);
		// a write without its low byte lane must leave the register alone
		wstrb <= 4'h0;
		wr(ADDR_CHANNEL_SELECT, 32'h00000000);
		wstrb <= 4'hF;
		rdchk(ADDR_CHANNEL_SELECT, 32'h000000A5);
		wr(32'hFFFFE810, 32'h000000FF);
		chk(last_resp, RESP_SLVERR);
		rd(32'hFFFFE810, d);
		chk(d, 32'h00000000);
		chk(last_resp, RESP_SLVERR);
	endtask

	// four channels, slow core: order, results, hold stages, self-clearing start
	task automatic t_single;
		base = 9'h15A;
		slow = 1'b1;
		clear_flags();
		wr(ADDR_CHANNEL_SELECT, 32'h0000000F);
		wr(ADDR_SCAN_CONTROL, 32'h00000001);
		wait_flag();
		rdchk(ADDR_SCAN_CONTROL, 32'h00000000);
		chk(32'(ch_q.size()), 32'h4);
		for (int i = 0; i < 4; i++) begin
			chk(ch_q[i], 32'(i));
			chk(hold_q[i], (32'h7 << i) & 32'h7);
			chk(sh_q[i], i < 3);
			rdchk(ADDR_RESULT_BASE + 32'(4 * i), res(i));
			rdchk(ADDR_RESULT_BASE + 32'(4 * i), res(i));
		end
		rdchk(ADDR_RESULT_BASE + 32'h10, 32'h00000000);
		wr(ADDR_CONV_STATUS, 32'h00000000);
		rdchk(ADDR_CONV_STATUS, 32'h00000000);
	endtask

	// repeated scans of channels 0 and 2 until software stops them
	task automatic t_cont;
		logic [31:0] d;
		int n;
		clear_flags();
		base = 9'h0C3;
		wr(ADDR_CHANNEL_SELECT, 32'h00000005);
		wr(ADDR_SCAN_CONTROL, 32'h00000041);
		while (ch_q.size() < 6) @(posedge clk);
		rdchk(ADDR_SCAN_CONTROL, 32'h00000041);
		wr(ADDR_SCAN_CONTROL, 32'h00000040);
		do rd(ADDR_CONV_STATUS, d); while (d[STAT_BUSY] !== 1'b0);
		n = ch_q.size();
		repeat (20) @(posedge clk);
		chk(32'(ch_q.size()), 32'(n));
		for (int i = 0; i < n; i++) begin
			chk(ch_q[i], 32'((i % 2) * 2));
		end
		rdchk(ADDR_RESULT_BASE + 32'h8, res(2));
		clear_flags();
	endtask

	task automatic t_ace;
		base = 9'h1F0;
		slow = 1'b0;
		wr(ADDR_CHANNEL_SELECT, 32'h00000002);
		wr(ADDR_SCAN_CONTROL, 32'h00000021);
		wait_flag();
		rdchk(ADDR_RESULT_BASE + 32'h4, res(1));
		rdchk(ADDR_RESULT_BASE + 32'h4, 32'h00000000);
		clear_flags();
	endtask

	// interrupt gated by enable, then masked, unmasked and cleared
	task automatic t_irq;
		wr(ADDR_IRQ_MASK, 32'h00000001);
		wr(ADDR_SCAN_CONTROL, 32'h00000001);
		wait_flag();
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		clear_flags();
		wr(ADDR_SCAN_CONTROL, 32'h00000011);
		wait_flag();
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		wr(ADDR_IRQ_MASK, 32'h00000000);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wr(ADDR_IRQ_MASK, 32'h00000001);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		clear_flags();
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wr(ADDR_SCAN_CONTROL, 32'h00000000);
	endtask

	// source 0..6 are timer pulses, 7 is a falling edge on the external pin
	task automatic pulse(input int i);
		@(posedge clk);
		if (i < 7) trg <= 7'(1 << i);
		else ext_n <= 1'b0;
		@(posedge clk);
		trg <= 7'h00;
		repeat (3) @(posedge clk);
		ext_n <= 1'b1;
	endtask

	task automatic t_trig;
		wr(ADDR_CHANNEL_SELECT, 32'h00000001);
		for (int i = 0; i < 8; i++) pulse(i);
		repeat (10) @(posedge clk);
		chk(32'(ch_q.size()), 32'h0);
		wr(ADDR_SCAN_CONTROL, 32'h00000002);
		for (int i = 0; i < 8; i++) begin
			pulse(i);
			wait_flag();
			chk(32'(ch_q.size()), 32'h1);
			clear_flags();
		end
		// a second trigger while the scan still runs is dropped but marked as overrun
		pulse(0);
		pulse(1);
		wait_flag();
		chk(32'(ch_q.size()), 32'h1);
		rdchk(ADDR_IRQ_STATUS, 32'h00000003);
	endtask

	// inputs settled at time zero, reset for ten cycles, then each scenario in turn
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		trg = 7'h00;
		ext_n = 1'b1;
		slow = 1'b0;
		base = 9'h000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_single();
		t_cont();
		t_ace();
		t_irq();
		t_trig();
		end_of_test();
	end
endmodule
